/* File: inc/adc_regs_pkg.sv */
// Purpose: Shared constants for the sync, range and power-mode register slice.
// Assumes: Byte-wide registers on a 15-bit serial-port address.
// Notes:   Multi-byte registers hold their least significant byte at the base.
`default_nettype none
package adc_regs_pkg;
    // ========================================
    // Serial frame layout
    localparam int ADDR_W = 15;
    localparam int CMD_BITS = 16;
    localparam int DATA_BITS = 8;
    localparam logic [4:0] CMD_LAST = 5'h0f;
    localparam logic [4:0] DATA_LAST = 5'h07;
    // ========================================
    // Register offsets
    localparam logic [14:0] POS_ADDR0 = 15'h002c;
    localparam logic [14:0] FS_ADDR0 = 15'h0030;
    localparam logic [14:0] PMODE_ADDR = 15'h0037;
    // ========================================
    // Widths and reset values
    localparam int POS_W = 24;
    localparam int FS_BYTES = 2;
    localparam logic [23:0] POS_RESET = 24'h000000;
    localparam logic [15:0] FS_RESET = 16'ha000;
    localparam logic [7:0] PMODE_RESET = 8'h4b;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    // ========================================
    // Field codes
    localparam logic [15:0] FS_MIN_GOOD = 16'h2000;
    localparam logic [15:0] FS_MAX = 16'hffff;
    localparam logic [7:0] PMODE_LOW = 8'h46;
    localparam logic [7:0] PMODE_HIGH = 8'h4b;
endpackage
`default_nettype wire

/* File: inc/reg_byte_if.sv */
// Purpose: Byte access path from the serial port to the register bank.
// Assumes: wr and rd are one-cycle pulses; rdata is valid the cycle after rd.
// Notes:   addr and wdata are held steady while a strobe is high.
`timescale 1ns/10ps
`default_nettype none
interface reg_byte_if;
    logic [14:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    modport port (output addr, output wdata, output wr, output rd, input rdata);
    modport regs (input addr, input wdata, input wr, input rd, output rdata);
endinterface
`default_nettype wire

/* File: logic/serial_reg_port.sv */
// Purpose: Serial control port slave turning frames into byte register accesses.
// Assumes: sclk idles low, at most clk/4; sdi sampled on sclk rise, sdo moves on fall.
// Notes:   Frame is R/W bit, 15-bit address, then data bytes with auto-increment.
`timescale 1ns/10ps
`default_nettype none
module serial_reg_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    reg_byte_if.port bus
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CMD = 3'b010,
        ST_DATA = 3'b100
    } port_state_t;

    port_state_t state_q;
    logic sclk_q;
    logic rise;
    logic fall;
    logic [4:0] cnt_q;
    logic [15:0] cmd_q;
    logic [7:0] wsh_q;
    logic [7:0] tx_q;
    logic rnw_q;
    logic load_q;
    logic [14:0] addr_q;
    logic [7:0] wdata_q;
    logic wr_q;
    logic rd_q;

    // ========================================
    // Edge detection on the sampled serial clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
        end
    end
    assign rise = sclk & ~sclk_q & ~cs_n;
    assign fall = ~sclk & sclk_q & ~cs_n;

    // ========================================
    // Frame sequencer; chip select high aborts any frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            cmd_q <= 16'h0000;
            wsh_q <= 8'h00;
            rnw_q <= 1'b0;
        end else if (cs_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_q <= ST_CMD;
                    cnt_q <= 5'h00;
                end
                ST_CMD: begin
                    if (rise) begin
                        cmd_q <= {cmd_q[14:0], sdi};
                        cnt_q <= (cnt_q == adc_regs_pkg::CMD_LAST) ? 5'h00 : cnt_q + 5'h01;
                        if (cnt_q == adc_regs_pkg::CMD_LAST) begin
                            state_q <= ST_DATA;
                            rnw_q <= cmd_q[14];
                        end
                    end
                end
                ST_DATA: begin
                    if (rise) begin
                        wsh_q <= {wsh_q[6:0], sdi};
                        cnt_q <= (cnt_q == adc_regs_pkg::DATA_LAST) ? 5'h00 : cnt_q + 5'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // Access strobes, address and auto-increment
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= 15'h0000;
            wdata_q <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (wr_q) begin
                addr_q <= addr_q + 15'h0001; // Step only after the write landed
            end
            if (!cs_n && rise && state_q == ST_CMD && cnt_q == adc_regs_pkg::CMD_LAST) begin
                addr_q <= {cmd_q[13:0], sdi};
                rd_q <= cmd_q[14];
            end
            if (!cs_n && rise && state_q == ST_DATA && cnt_q == adc_regs_pkg::DATA_LAST) begin
                if (rnw_q) begin
                    addr_q <= addr_q + 15'h0001; // Prefetch next byte of a burst
                    rd_q <= 1'b1;
                end else begin
                    wdata_q <= {wsh_q[6:0], sdi};
                    wr_q <= 1'b1;
                end
            end
        end
    end

    // ========================================
    // Read shifter: fresh byte on the fall after a read, else shift
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= 8'h00;
            load_q <= 1'b0;
        end else begin
            if (rd_q) begin
                load_q <= 1'b1;
            end else if (fall && load_q) begin
                load_q <= 1'b0;
            end
            if (fall && load_q) begin
                tx_q <= bus.rdata;
            end else if (fall && state_q == ST_DATA) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    assign sdo = tx_q[7];
    assign sdo_oe = ~cs_n & rnw_q & (state_q == ST_DATA);
    assign bus.addr = addr_q;
    assign bus.wdata = wdata_q;
    assign bus.wr = wr_q;
    assign bus.rd = rd_q;
endmodule
`default_nettype wire

/* File: logic/adc_sync_range_power_regs.sv */
// Purpose: Edge-position status, shared full-scale setting and power-mode code.
// Assumes: Accessed over the serial control port; capture inputs synchronous to clk.
// Notes:   Byte registers; unmapped addresses read zero and ignore writes.
// Operation
// RQ1: Read-only 24-bit status shows SYSREF edge position relative to sampling clock.
// RQ2: Edge-position status resets to zero and ignores writes.
// RQ3: Host picks the SYSREF delay select from the read-back position.
// RQ4: One 16-bit full-scale setting drives the range of all channels together.
// RQ5: Full-scale setting resets to 0xA000, an 800 mVPP range.
// RQ6: Host should keep full-scale at or above 0x2000, 500 mVPP.
// RQ7: Codes below 0x2000 are stored anyway, flagged as degraded performance.
// RQ8: Full-scale code 0xFFFF selects the largest range, 1000 mVPP.
// RQ9: First power-mode code register is eight bits, read-write, reset 0x4B.
// RQ10: Code 0x46 is low power, 0x4B high performance, others reserved.
// RQ11: Host writes all four power-mode registers together, then calibrates.
// RQ12: Host clears calibration and serial link enables before changing the code.
// RQ13: Fine-step option shrinks the delay steps seen in the position status.
// RQ14: Reading the position status returns it and never alters it.
`timescale 1ns/10ps
`default_nettype none
module adc_sync_range_power_regs #(
    parameter int POS_W = adc_regs_pkg::POS_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic capture_valid,
    input wire logic [POS_W-1:0] capture_position,
    input wire logic sysref_fine_step,
    output logic fine_step_active,
    output logic [15:0] full_scale_setting,
    output logic range_degraded,
    output logic range_at_max,
    output logic [7:0] power_mode_code_first,
    output logic low_power_mode,
    output logic high_perf_mode,
    output logic power_code_reserved
);
    localparam int POS_BYTES = POS_W / 8;

    // ========================================
    // Parameter check
    if (POS_W % 8 != 0 || POS_W < 8 || POS_W > 32) begin : g_bad_width
        $error("position width must be 8 to 32 in whole bytes");
    end

    reg_byte_if bus ();
    logic [POS_W-1:0] pos_q;
    logic [7:0] fs_byte_q [adc_regs_pkg::FS_BYTES];
    logic [15:0] fs_q;
    logic [7:0] pm_q;
    logic fine_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [4:0] pos_idx;
    logic after_rst_q;

    // Address window decode, used by the read mux and the status write check
    function automatic logic in_window(input logic [14:0] a, input logic [14:0] base,
                                       input int n);
        in_window = (a >= base) && (a < base + 15'(n));
    endfunction

    serial_reg_port u_port (
        .clk(clk),
        .rst_n(rst_n),
        .sclk(spi_sclk),
        .cs_n(spi_cs_n),
        .sdi(spi_sdi),
        .sdo(spi_sdo),
        .sdo_oe(spi_sdo_oe),
        .bus(bus)
    );

    // ========================================
    // Edge-position status: loaded only by the detector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_q <= POS_W'(adc_regs_pkg::POS_RESET); // [RQ2]
        end else if (capture_valid) begin
            pos_q <= capture_position; // [RQ1] [RQ14]
        end
    end

    property p_pos_capture;
        @(posedge clk) disable iff (!rst_n)
        capture_valid |=> pos_q == $past(capture_position);
    endproperty
    a_pos_capture: assert property (p_pos_capture) // [RQ1]
        else $error("position not captured");

    property p_pos_ignores_write;
        @(posedge clk) disable iff (!rst_n)
        bus.wr && in_window(bus.addr, adc_regs_pkg::POS_ADDR0, POS_BYTES) && !capture_valid
        |=> $stable(pos_q);
    endproperty
    a_pos_ignores_write: assert property (p_pos_ignores_write) // [RQ2]
        else $error("status was written");

    property p_read_keeps_pos;
        @(posedge clk) disable iff (!rst_n)
        bus.rd && !capture_valid ##1 !capture_valid |=> pos_q == $past(pos_q, 2);
    endproperty
    a_read_keeps_pos: assert property (p_read_keeps_pos) // [RQ14]
        else $error("read altered status");

    // Fine-step option to the delay chain; registered to keep it glitch free
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fine_q <= 1'b0;
        end else begin
            fine_q <= sysref_fine_step; // [RQ13]
        end
    end
    assign fine_step_active = fine_q;

    property p_fine_step;
        @(posedge clk) disable iff (!rst_n)
        $rose(sysref_fine_step) |=> fine_step_active ##1 (fine_step_active == $past(sysref_fine_step));
    endproperty
    a_fine_step: assert property (p_fine_step) // [RQ13]
        else $error("fine step not applied");

    // ========================================
    // Full-scale setting, one byte register per byte of the 16-bit code
    for (genvar b = 0; b < adc_regs_pkg::FS_BYTES; b++) begin : g_fs
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                fs_byte_q[b] <= adc_regs_pkg::FS_RESET[8*b +: 8]; // [RQ5]
            end else if (bus.wr && bus.addr == adc_regs_pkg::FS_ADDR0 + 15'(b)) begin
                fs_byte_q[b] <= bus.wdata; // [RQ7]
            end
        end
    end
    assign fs_q = {fs_byte_q[1], fs_byte_q[0]};
    // Bytes apply as written, so a two-byte update passes one mixed code
    assign full_scale_setting = fs_q; // [RQ4]
    assign range_degraded = fs_q < adc_regs_pkg::FS_MIN_GOOD; // [RQ7]
    assign range_at_max = fs_q == adc_regs_pkg::FS_MAX; // [RQ8]

    property p_reset_values;
        @(posedge clk) disable iff (!rst_n)
        !after_rst_q |-> full_scale_setting == 16'ha000 && pos_q == '0;
    endproperty
    a_reset_values: assert property (p_reset_values) // [RQ5]
        else $error("bad reset value");

    property p_fs_low_stored;
        @(posedge clk) disable iff (!rst_n)
        bus.wr && bus.addr == 15'h0031 && bus.wdata < 8'h20
        |=> range_degraded && full_scale_setting[15:8] == $past(bus.wdata);
    endproperty
    a_fs_low_stored: assert property (p_fs_low_stored) // [RQ7] [RQ4]
        else $error("low code lost");

    property p_fs_max;
        @(posedge clk) disable iff (!rst_n)
        bus.wr && bus.addr == 15'h0031 && bus.wdata == 8'hff && fs_q[7:0] == 8'hff
        |=> range_at_max && !range_degraded;
    endproperty
    a_fs_max: assert property (p_fs_max) // [RQ8]
        else $error("max range not seen");

    // ========================================
    // Power-mode code; reserved codes are kept but flagged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_q <= adc_regs_pkg::PMODE_RESET; // [RQ9]
        end else if (bus.wr && bus.addr == adc_regs_pkg::PMODE_ADDR) begin
            pm_q <= bus.wdata; // [RQ9]
        end
    end
    assign power_mode_code_first = pm_q;
    assign low_power_mode = pm_q == adc_regs_pkg::PMODE_LOW; // [RQ10]
    assign high_perf_mode = pm_q == adc_regs_pkg::PMODE_HIGH; // [RQ10]
    assign power_code_reserved = ~low_power_mode & ~high_perf_mode; // [RQ10]

    property p_pm_reset;
        @(posedge clk) disable iff (!rst_n)
        !after_rst_q |-> power_mode_code_first == 8'h4b && high_perf_mode;
    endproperty
    a_pm_reset: assert property (p_pm_reset) // [RQ9]
        else $error("power mode reset wrong");

    property p_pm_low;
        @(posedge clk) disable iff (!rst_n)
        bus.wr && bus.addr == 15'h0037 && bus.wdata == 8'h46
        |=> low_power_mode && !high_perf_mode && !power_code_reserved;
    endproperty
    a_pm_low: assert property (p_pm_low) // [RQ10]
        else $error("low power decode wrong");

    // ========================================
    // Read path: byte mux, registered; reads have no side effect
    assign pos_idx = 5'(bus.addr - adc_regs_pkg::POS_ADDR0);
    always_comb begin
        rdata_d = adc_regs_pkg::UNMAPPED_DATA;
        if (in_window(bus.addr, adc_regs_pkg::POS_ADDR0, POS_BYTES)) begin
            rdata_d = 8'(pos_q >> {pos_idx, 3'b000}); // [RQ1] [RQ14]
        end else if (in_window(bus.addr, adc_regs_pkg::FS_ADDR0, adc_regs_pkg::FS_BYTES)) begin
            rdata_d = 8'(fs_q >> {bus.addr[0], 3'b000});
        end else if (bus.addr == adc_regs_pkg::PMODE_ADDR) begin
            rdata_d = pm_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (bus.rd) begin
            rdata_q <= rdata_d;
        end
    end
    assign bus.rdata = rdata_q;

    property p_pm_readback;
        @(posedge clk) disable iff (!rst_n)
        bus.rd && bus.addr == 15'h0037 |=> bus.rdata == $past(pm_q);
    endproperty
    a_pm_readback: assert property (p_pm_readback) // [RQ9]
        else $error("mode readback wrong");

    // ========================================
    // Checks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            after_rst_q <= 1'b0;
        end else begin
            after_rst_q <= 1'b1;
        end
    end

endmodule
`default_nettype wire

/* File: bench/spi_host_model.sv */
// Purpose: Host controller model driving the serial control port.
// Assumes: Called at 1 ns after a clk rise; sclk phases of HALF clk each.
// Notes:   Bytes go low byte first at rising addresses, each byte MSB first.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model #(
    parameter int HALF = 4
) (
    input wire logic clk,
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    // ========================================
    // Idle levels
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // One bit: data set while sclk low, read data taken at end of high phase
    task automatic bit_io(input logic b, output logic got);
        sdi = b;
        repeat (HALF) @(posedge clk);
        #1 sclk = 1'b1;
        repeat (HALF) @(posedge clk);
        #1 got = sdo;
        sclk = 1'b0;
    endtask

    // Whole frame; sclk stands still low outside it
    task automatic frame(input logic rw, input logic [14:0] addr, input int n,
                         input logic [31:0] wdat, output logic [31:0] rdat);
        logic [15:0] hdr;
        logic g;
        hdr = {rw, addr};
        rdat = 32'h00000000;
        cs_n = 1'b0;
        @(posedge clk);
        #1;
        for (int i = 15; i >= 0; i--) begin
            bit_io(hdr[i], g);
        end
        for (int k = 0; k < n; k++) begin
            for (int j = 7; j >= 0; j--) begin
                bit_io(wdat[8*k+j], g);
                rdat[8*k+j] = g;
            end
        end
        repeat (HALF) @(posedge clk);
        #1 cs_n = 1'b1;
        sdi = ~sdi; // Released line no longer shows the last bit
        repeat (3) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* File: bench/test_adc_sync_range_power_regs.sv */
// Purpose: Self-checking bench for the sync, range and power-mode registers.
// Assumes: Host model owns the serial pins; capture inputs driven here.
// Notes:   Fixed seed; corner codes mixed with random ones.
`timescale 1ns/10ps
`default_nettype none
module test_adc_sync_range_power_regs;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe;
    logic capture_valid = 1'b0;
    logic [23:0] capture_position = 24'h000000;
    logic sysref_fine_step = 1'b0;
    logic fine_step_active, range_degraded, range_at_max;
    logic low_power_mode, high_perf_mode, power_code_reserved;
    logic [15:0] full_scale_setting;
    logic [7:0] power_mode_code_first;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    int oe_cycles = 0;
    int oe_base;
    logic [31:0] rd;
    logic [15:0] fs;
    logic [7:0] code;
    logic [23:0] pos;
    logic [15:0] fs_corner [5] = '{16'h0000, 16'h1fff, 16'h2000, 16'ha000, 16'hffff};
    logic [7:0] mode_corner [5] = '{8'h46, 8'h4b, 8'h00, 8'h47, 8'hff};

    adc_sync_range_power_regs #(.POS_W(24)) i_dut (.clk(clk), .rst_n(rst_n),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe), .capture_valid(capture_valid),
        .capture_position(capture_position), .sysref_fine_step(sysref_fine_step),
        .fine_step_active(fine_step_active), .full_scale_setting(full_scale_setting),
        .range_degraded(range_degraded), .range_at_max(range_at_max),
        .power_mode_code_first(power_mode_code_first), .low_power_mode(low_power_mode),
        .high_perf_mode(high_perf_mode), .power_code_reserved(power_code_reserved));
    spi_host_model #(.HALF(4)) i_host (.clk(clk), .sclk(spi_sclk), .cs_n(spi_cs_n),
        .sdi(spi_sdi), .sdo(spi_sdo));

    // ========================================
    // Clock and hang guard, sized well above the ~11k cycles of traffic
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        oe_cycles <= oe_cycles + int'(spi_sdo_oe); // Edges with the read driver on
        if (cycles == 30000) begin
            fails++;
            end_of_test();
        end
    end

    // ========================================
    // Expectations and checking
    function automatic logic [2:0] mode_decode(input logic [7:0] c);
        return {c == adc_regs_pkg::PMODE_LOW, c == adc_regs_pkg::PMODE_HIGH,
                c != adc_regs_pkg::PMODE_LOW && c != adc_regs_pkg::PMODE_HIGH};
    endfunction
    function automatic logic [1:0] range_flags(input logic [15:0] v);
        return {v < adc_regs_pkg::FS_MIN_GOOD, v == adc_regs_pkg::FS_MAX};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
        logic [31:0] unused;
        i_host.frame(1'b0, a, n, d, unused);
    endtask
    task automatic rd_reg(input logic [14:0] a, input int n, output logic [31:0] d);
        i_host.frame(1'b1, a, n, 32'($urandom), d);
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        rd = $urandom(32'hd2184973);
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        @(posedge clk);
        #1;
        // Reset state at the ports and over the serial port
        check("mode flags reset", {low_power_mode, high_perf_mode, power_code_reserved},
              mode_decode(adc_regs_pkg::PMODE_RESET));
        check("range flags reset", {range_degraded, range_at_max}, 2'b00);
        rd_reg(adc_regs_pkg::POS_ADDR0, 3, rd);
        check("position reset", rd, 32'h00000000);
        rd_reg(adc_regs_pkg::FS_ADDR0, 2, rd);
        check("full scale reset", rd, 32'h0000a000);
        rd_reg(adc_regs_pkg::PMODE_ADDR, 1, rd);
        check("power mode reset", rd, 32'h0000004b);
        // Captures, with a write attempt and a second read each time
        for (int i = 0; i < 3; i++) begin
            pos = (i == 0) ? 24'hffffff : 24'($urandom);
            capture_valid = 1'b1;
            capture_position = pos;
            @(posedge clk);
            #1 capture_valid = 1'b0;
            capture_position = ~pos;
            wr(adc_regs_pkg::POS_ADDR0, 3, {8'h00, ~pos});
            rd_reg(adc_regs_pkg::POS_ADDR0, 3, rd); // Host picks delay select from this
            check("position read", rd, {8'h00, pos});
            rd_reg(adc_regs_pkg::POS_ADDR0, 3, rd);
            check("position reread", rd, {8'h00, pos});
        end
        // Unmapped byte between status and range
        oe_base = oe_cycles;
        wr(15'h002f, 1, 32'h000000ff);
        check("sdo enable write", oe_cycles - oe_base, 32'h0);
        rd_reg(15'h002f, 1, rd);
        check("unmapped read", rd, 32'h00000000);
        // Driver must cover all eight data bits, each two half periods of four clocks
        check("sdo enable read", 32'(oe_cycles - oe_base >= 64), 32'h1);
        check("sdo enable idle", spi_sdo_oe, 1'b0);
        // Range codes: corners first, the two low ones on purpose below advice
        for (int i = 0; i < 9; i++) begin
            fs = (i < 5) ? fs_corner[i] : 16'(($urandom % 32'he000) + 32'h2000);
            wr(adc_regs_pkg::FS_ADDR0, 2, {16'h0000, fs});
            check("full scale out", full_scale_setting, fs);
            check("range flags", {range_degraded, range_at_max}, range_flags(fs));
            rd_reg(adc_regs_pkg::FS_ADDR0, 2, rd);
            check("full scale read", rd, {16'h0000, fs});
        end
        // Power-mode codes; calibration and link enables live outside, taken as cleared
        for (int i = 0; i < 5; i++) begin
            code = (i == 2) ? 8'($urandom) : mode_corner[i];
            wr(adc_regs_pkg::PMODE_ADDR, 1, {24'h000000, code});
            check("power mode out", power_mode_code_first, code);
            check("mode flags", {low_power_mode, high_perf_mode, power_code_reserved},
                  mode_decode(code));
            rd_reg(adc_regs_pkg::PMODE_ADDR, 1, rd);
            check("power mode read", rd, {24'h000000, code});
        end
        check("full scale kept", full_scale_setting, fs);
        // Fine-step option follows one clock later
        for (int i = 0; i < 4; i++) begin
            sysref_fine_step = (i < 2) ? ~sysref_fine_step : 1'($urandom);
            @(posedge clk);
            #1;
            check("fine step", fine_step_active, sysref_fine_step);
        end
        // Mid-run reset puts the stored settings back
        @(posedge clk);
        #1 rst_n = 1'b0;
        @(posedge clk);
        #1;
        check("full scale in reset", full_scale_setting, adc_regs_pkg::FS_RESET);
        check("power mode in reset", power_mode_code_first, adc_regs_pkg::PMODE_RESET);
        check("fine step in reset", fine_step_active, 1'b0);
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        rd_reg(adc_regs_pkg::POS_ADDR0, 3, rd);
        check("position after reset", rd, 32'h00000000);
        end_of_test();
    end
endmodule
`default_nettype wire
